// ---- pbs_port.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - All synchronous inputs are captured on the rising clock edge only.
// - Address registers only on a strobe edge with all selects active.
// - A strobe loads the address and its two low bits into the counter.
// - The two low address bits feed a two-bit burst counter.
// - Both strobes low with primary select low: only the processor strobe is acted upon.
// - Processor strobe is ignored while primary select is sampled high.
// - Selected when primary low, second high and third low.
// - Selects are sampled only on address loads, not burst advances.
// - Without a third select pin, it behaves as permanently asserted.
// - Advance low during a burst steps the counter each edge.
// - A lane select writes only with lane write qualify also low.
// - Global write low writes every lane, ignoring lane controls.
// - Output enable low drives data pins; high releases them as inputs.
// - Output enable is masked first read clock after a deselect.
// - Sleep high idles the port, contents kept; low runs normally.
// - Order strap low gives linear bursts, high or open interleaved.
// - Read data come from the address of the previous edge.
// - The counter holds the start and wraps inside four addresses.
module pbs_port #(
  parameter bit HAS_THIRD_SELECT = 1'b1
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Address and control.
  input  wire pbs_pkg::pbs_ctrl_t          ctrl,
  input  wire pbs_pkg::pbs_write_t         wr,
  // Static and asynchronous controls.
  input  wire logic                        burst_order_sel,
  input  wire logic                        output_enable_n,
  input  wire logic                        sleep_request,
  // Data pins, split into input, output and enable (low drives).
  input  wire logic [pbs_pkg::DATA_W-1:0]  data_in,
  output logic      [pbs_pkg::DATA_W-1:0]  data_out,
  output logic                             data_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [pbs_pkg::ADDR_W-1:0]  base;
    logic [pbs_pkg::BURST_W-1:0] start;
    logic [pbs_pkg::BURST_W-1:0] count;
    pbs_pkg::pbs_mode_t          mode;
    logic                        first_read;
    logic                        read_valid;
    logic                        order_linear;
    logic                        strap_taken;
  } pbs_state_t;

  pbs_state_t                  st;
  pbs_state_t                  next_st;
  logic                        selected;
  logic                        cpu_load;
  logic                        ctrl_load;
  logic                        any_strobe;
  logic                        is_write;
  logic [pbs_pkg::LANES-1:0]   lane_we;
  logic [pbs_pkg::BURST_W-1:0] low_bits;
  logic [pbs_pkg::ADDR_W-1:0]  mem_addr;
  logic [pbs_pkg::DATA_W-1:0]  rdata;
  logic                        third_ok;
  logic                        load;
  logic                        burst_go;
  logic                        step_req;
  logic [pbs_pkg::BURST_W-1:0] step_count;
  logic [pbs_pkg::LANES-1:0]   mem_we;
  logic                        write_ok;
  logic                        oe_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Select decode.
  always_comb begin
    third_ok = HAS_THIRD_SELECT ? !ctrl.third_select_n : 1'b1;
    selected = !ctrl.primary_select_n && ctrl.second_select_hi && third_ok;
  end

  // Strobe qualification; sleep suppresses all new activity.
  always_comb begin
    cpu_load  = !sleep_request && !ctrl.cpu_addr_strobe_n &&
                !ctrl.primary_select_n;
    ctrl_load = !sleep_request && !ctrl.ctrl_addr_strobe_n && !cpu_load;
    any_strobe = cpu_load || ctrl_load;
  end

  for (genvar g = 0; g < pbs_pkg::LANES; g++) begin : g_lane_we
    assign lane_we[g] = !wr.all_lanes_write_n ||
                        (!wr.lane_write_qualify_n && !wr.lane_write_sel_n[g]);
  end

  // A processor-strobe cycle is always taken as a read; writes follow.
  always_comb begin
    is_write = (lane_we != pbs_pkg::LANES_NONE) && !cpu_load;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode.
  always_comb begin
    load     = any_strobe && selected;
    burst_go = !any_strobe && !sleep_request &&
               (st.mode != pbs_pkg::PBS_IDLE);
    step_req = burst_go && !ctrl.burst_step_n;
  end

  // The advance input moves the address of the very edge that samples it,
  // so the count held in the state names the word touched last.
  always_comb begin
    if (step_req) begin
      step_count = st.count + pbs_pkg::BURST_ONE;
    end else begin
      step_count = st.count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    next_st = st;
    // The strap is caught once after reset, since it must stay static.
    if (!st.strap_taken) begin
      next_st.order_linear = !burst_order_sel;
      next_st.strap_taken  = 1'b1;
    end
    next_st.read_valid = 1'b0;
    next_st.first_read = 1'b0;
    if (load) begin
      next_st.base       = ctrl.addr;
      next_st.start      = ctrl.addr[pbs_pkg::BURST_W-1:0];
      next_st.count      = pbs_pkg::BURST_ZERO;
      next_st.read_valid = !is_write;
      next_st.first_read = !is_write && (st.mode == pbs_pkg::PBS_IDLE);
    end else if (burst_go) begin
      next_st.count      = step_count;
      next_st.read_valid = !is_write;
    end
    // Idle, read and write follow one another in Gray order; the spare
    // code can only come from an upset, so it falls back to idle.
    unique case (st.mode)
      pbs_pkg::PBS_IDLE: begin
        if (load) begin
          next_st.mode = is_write ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
        end
      end
      pbs_pkg::PBS_READ,
      pbs_pkg::PBS_WRITE: begin
        // A deselect or sleep ends the burst.
        if (load || burst_go) begin
          next_st.mode = is_write ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
        end else begin
          next_st.mode = pbs_pkg::PBS_IDLE;
        end
      end
      default: begin
        next_st.mode = pbs_pkg::PBS_IDLE;
      end
    endcase
    if (sleep_request) begin
      next_st.mode = pbs_pkg::PBS_IDLE;
    end
    if (!rst_n) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst address and memory access.
  always_comb begin
    if (st.order_linear) begin
      low_bits = st.start + step_count;
    end else begin
      low_bits = st.start ^ step_count;
    end
    if (load) begin
      mem_addr = ctrl.addr;
    end else begin
      mem_addr = {st.base[pbs_pkg::ADDR_W-1:pbs_pkg::BURST_W], low_bits};
    end
  end

  // Writes are refused in reset, asleep, on a deselect and on any edge
  // that neither loads an address nor carries a burst on.
  always_comb begin
    write_ok = is_write && rst_n && (load || burst_go);
    if (write_ok) begin
      mem_we = lane_we;
    end else begin
      mem_we = pbs_pkg::LANES_NONE;
    end
  end

  // A write lands at the edge that samples the controls, at the address
  // that the same edge selects, burst step included.
  pbs_mem u_mem (
    .clk     (clk),
    .addr    (mem_addr),
    .lane_we (mem_we),
    .wdata   (data_in),
    .rdata   (rdata)
  );

  assign data_out = rdata;

  // The mask comes from registered state, so only the enable and sleep
  // reach the pins without waiting for a clock edge.
  always_comb begin
    oe_mask = !st.read_valid || st.first_read;
  end

  assign data_oe_n = output_enable_n || oe_mask || sleep_request;

endmodule : pbs_port

// ---- pbs_pkg.sv ----
package pbs_pkg;

  localparam int ADDR_W   = 18;
  localparam int LANES    = 4;
  localparam int LANE_W   = 9;
  localparam int DATA_W   = LANES * LANE_W;
  localparam int DEPTH    = 1 << ADDR_W;
  localparam int BURST_W  = 2;

  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
  localparam logic [LANES-1:0]   LANES_ALL  = 4'hF;

  // Access kind held across the cycle that follows an address load.
  typedef enum logic [1:0] {
    PBS_IDLE  = 2'b00,
    PBS_READ  = 2'b01,
    PBS_WRITE = 2'b11
  } pbs_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cpu_addr_strobe_n;
    logic              ctrl_addr_strobe_n;
    logic              burst_step_n;
    logic              primary_select_n;
    logic              second_select_hi;
    logic              third_select_n;
  } pbs_ctrl_t;

  typedef struct packed {
    logic             all_lanes_write_n;
    logic             lane_write_qualify_n;
    logic [LANES-1:0] lane_write_sel_n;
  } pbs_write_t;

endpackage : pbs_pkg

// ---- pbs_mem.sv ----
`timescale 1ns/1ps
module pbs_mem (
  // Clock.
  input  wire logic                         clk,
  // Access.
  input  wire logic [pbs_pkg::ADDR_W-1:0]   addr,
  input  wire logic [pbs_pkg::LANES-1:0]    lane_we,
  input  wire logic [pbs_pkg::DATA_W-1:0]   wdata,
  output logic      [pbs_pkg::DATA_W-1:0]   rdata
);

  logic [pbs_pkg::DATA_W-1:0] mem [pbs_pkg::DEPTH];

  // Read data comes out of a register; a write to the same word returns
  // the old contents, which the port never relies on.
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end

  // One process owns the array, so the lanes cannot become rival drivers.
  always_ff @(posedge clk) begin
    for (int g = 0; g < pbs_pkg::LANES; g++) begin
      if (lane_we[g]) begin
        mem[addr][g*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] <=
          wdata[g*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
      end
    end
  end

endmodule : pbs_mem

// ---- pbs_master.sv ----
`timescale 1ns/1ps
module pbs_master (
  // Clock.
  input  wire logic                       clk,
  // Device side of the data pins.
  input  wire logic [pbs_pkg::DATA_W-1:0] dev_q,
  input  wire logic                       dev_oe_n,
  // Master side of the data pins.
  input  wire logic [pbs_pkg::DATA_W-1:0] mst_d,
  input  wire logic                       mst_oe_n,
  output logic      [pbs_pkg::DATA_W-1:0] pin
);
  logic [pbs_pkg::DATA_W-1:0] last;
  // A released bus must not look like stale data, so it shows the inverse.
  assign pin = !mst_oe_n ? mst_d : (!dev_oe_n ? dev_q : ~last);
  always_ff @(posedge clk) last <= pin;
endmodule : pbs_master

// ---- pbs_port_asserts.sv ----
`timescale 1ns/1ps
module pbs_port_asserts (
  // Clock and reset.
  input wire logic                       clk,
  input wire logic                       rst_n,
  // Inputs of the port.
  input wire pbs_pkg::pbs_ctrl_t         ctrl,
  input wire pbs_pkg::pbs_write_t        wr,
  input wire logic                       burst_order_sel,
  input wire logic                       output_enable_n,
  input wire logic                       sleep_request,
  input wire logic [pbs_pkg::DATA_W-1:0] data_in,
  // Outputs of the port.
  input wire logic [pbs_pkg::DATA_W-1:0] data_out,
  input wire logic                       data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       sel, cpu, stb, rd, dsl, wall, lw0;
  logic [8:0] lo;
  assign lo   = data_in[8:0];
  assign sel  = !ctrl.primary_select_n && ctrl.second_select_hi
                && !ctrl.third_select_n;
  assign cpu  = !ctrl.cpu_addr_strobe_n && !ctrl.primary_select_n;
  assign stb  = (cpu || !ctrl.ctrl_addr_strobe_n) && !sleep_request;
  assign rd   = stb && sel && (cpu || (wr.all_lanes_write_n
                && (wr.lane_write_qualify_n || &wr.lane_write_sel_n)));
  assign dsl  = stb && !sel;
  assign wall = stb && sel && !cpu && !wr.all_lanes_write_n;
  assign lw0  = stb && sel && !cpu && wr.all_lanes_write_n
                && !wr.lane_write_qualify_n && !wr.lane_write_sel_n[0];
  a_oe_release: assert property (output_enable_n |-> data_oe_n)
    else $error("data pins driven with output enable high");
  a_sleep_quiet: assert property (sleep_request |-> data_oe_n)
    else $error("data pins driven while asleep");
  a_desel_idle: assert property (dsl |=> data_oe_n)
    else $error("data pins driven after a deselect");
  a_first_mask: assert property (dsl ##1 rd |=> data_oe_n)
    else $error("output enable not masked on first read");
  a_cpu_ignored: assert property (dsl ##1 (!ctrl.cpu_addr_strobe_n
    && ctrl.primary_select_n && ctrl.ctrl_addr_strobe_n) |=> data_oe_n)
    else $error("processor strobe taken while unselected");
  a_read_drive: assert property (rd ##1 rd |=>
    data_oe_n == (output_enable_n || sleep_request))
    else $error("read data not driven");
  a_same_word: assert property (rd ##1 (rd && $stable(ctrl.addr))
    |=> $stable(data_out)) else $error("same word read differently");
  a_global_write: assert property (wall ##1 (rd
    && $stable(ctrl.addr)) |=> data_out == $past(data_in, 2))
    else $error("global write not stored");
  a_lane_write: assert property (lw0 ##1 (rd
    && $stable(ctrl.addr)) |=> data_out[8:0] == $past(lo, 2))
    else $error("lane write not stored");
  c_mask: cover property (dsl ##1 rd);
  c_write_read: cover property (wall ##1 rd);
  c_burst: cover property (rd ##1 (!ctrl.burst_step_n && !stb));
endmodule : pbs_port_asserts
bind pbs_port pbs_port_asserts pbs_port_asserts_i (.clk, .rst_n, .ctrl,
  .wr, .burst_order_sel, .output_enable_n, .sleep_request, .data_in,
  .data_out, .data_oe_n);

// ---- pipelined_burst_sram_port_tb.sv ----
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb;
  localparam int W = pbs_pkg::DATA_W;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic order = 1'b0;
  logic oe_n = 1'b1;
  logic sleep = 1'b0;
  logic mst_oe_n = 1'b1;
  logic q_oe_n, act, first, chk, hi;
  logic [W-1:0] mst_d = '0;
  logic [W-1:0] pin, q, eq;
  logic [W-1:0] mem [8];
  logic [31:0] r = 32'hE924;
  logic [1:0] s0, cnt;
  int fail_count = 0;
  int samples_checked = 0;
  pbs_pkg::pbs_ctrl_t ctrl = '1;
  pbs_pkg::pbs_write_t wr = '1;
  pbs_port pbs_port_i (.clk, .rst_n, .ctrl, .wr, .burst_order_sel(order),
    .output_enable_n(oe_n), .sleep_request(sleep), .data_in(pin),
    .data_out(q), .data_oe_n(q_oe_n));
  pbs_master pbs_master_i (.clk, .dev_q(q), .dev_oe_n(q_oe_n), .mst_d,
    .mst_oe_n, .pin);
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] step(input logic [31:0] s);
    step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  function automatic logic [1:0] pos(input logic [1:0] s, c, input logic o);
    pos = o ? s ^ c : s + c;
  endfunction : pos
  task automatic check(input logic [W-1:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask : check
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic model();
    logic sl, cp, sb;
    logic [3:0] ln;
    logic [2:0] a;
    sl = !ctrl.primary_select_n && ctrl.second_select_hi
         && !ctrl.third_select_n;
    cp = !ctrl.cpu_addr_strobe_n && !ctrl.primary_select_n;
    sb = cp || !ctrl.ctrl_addr_strobe_n;
    ln = !wr.all_lanes_write_n ? 4'hF
       : (wr.lane_write_qualify_n ? 4'h0 : ~wr.lane_write_sel_n);
    chk = 1'b0;
    if (sleep || (sb && !sl)) begin
      act = 1'b0;
    end else if (sb || act) begin
      first = sb && !act;
      if (sb) begin
        {hi, s0} = ctrl.addr[2:0];
        cnt = 2'h0;
      end else if (!ctrl.burst_step_n) begin
        cnt++;
      end
      if (cp) ln = 4'h0;
      a = {hi, pos(s0, cnt, order)};
      for (int g = 0; g < 4; g++) if (ln[g]) mem[a][g*9+:9] = mst_d[g*9+:9];
      chk = (ln == 4'h0);
      eq = mem[a];
      act = 1'b1;
    end
  endtask : model
  initial begin
    for (int k = 0; k < 2; k++) begin
      rst_n <= 1'b0;
      order <= k[0];
      ctrl <= '1;
      wr <= '1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      act = 1'b0;
      @(posedge clk);
      for (int i = 0; i < 3000; i++) begin
        model();
        r = step(r);
        // Both strobes low; the write controls stay random.
        if (i % 50 == 0) r[7:4] = 4'h0;
        // Corner case: a global write to every word first, so reads are
        // compared against known data.
        if (k == 0 && i < 8) begin
          r[2:0] = i[2:0];
          r[19:4] = 16'h0101;
          r[31] = 1'b1;
        end
        ctrl <= {15'h0, r[2:0], r[4] | r[5], r[6] | r[7], r[8], &r[11:9],
                 |r[14:12], &r[17:15]};
        // Lane qualify travels with the lane selects.
        wr <= {r[18] | r[19], r[20], r[24:21]};
        mst_oe_n <= (r[18] | r[19]) & (r[20] | &r[24:21]);
        mst_d <= {r, r[31:28]};
        oe_n <= r[25] & r[26];
        sleep <= (r[31:27] == 5'h0);
        @(negedge clk);
        if (chk && !sleep) begin
          check(q, eq);
          check(W'(q_oe_n), W'(oe_n | first));
        end else if (!act) begin
          check(W'(q_oe_n), W'(1'b1));
        end
        @(posedge clk);
      end
      // The last random edge before the next reset still moves the memory.
      model();
    end
    close_out();
  end
  initial begin
    #800000;
    fail_count++;
    close_out();
  end
endmodule : pipelined_burst_sram_port_tb
